// ---- include/gsc_pkg.sv ----
package gsc_pkg;

	// command codes: each word sits on an even code (low byte) and the next odd one (high byte)
	localparam logic [7:0] CODE_CONTROL   = 8'h00;
	localparam logic [7:0] CODE_AT_RATE   = 8'h02;
	localparam logic [7:0] CODE_AR_TTE    = 8'h04;
	localparam logic [7:0] CODE_THERMAL   = 8'h06;
	localparam logic [7:0] CODE_POTENTIAL = 8'h08;
	localparam logic [7:0] CODE_INDICATOR = 8'h0a;
	localparam logic [7:0] CODE_NOM_AVAIL = 8'h0c;
	localparam logic [7:0] CODE_FULL_AVL  = 8'h0e;
	localparam logic [7:0] CODE_REMAIN    = 8'h10;
	localparam logic [7:0] CODE_FULL_CHG  = 8'h12;
	localparam logic [7:0] CODE_AVG_CUR   = 8'h14;
	localparam logic [7:0] CODE_RT_EMPTY  = 8'h16;
	localparam logic [7:0] CODE_RT_FULL   = 8'h18;
	localparam logic [7:0] CODE_SB_CUR    = 8'h1a;
	localparam logic [7:0] CODE_SB_RTE    = 8'h1c;
	localparam logic [7:0] CODE_ML_CUR    = 8'h1e;
	localparam logic [7:0] CODE_ML_RTE    = 8'h20;
	localparam logic [7:0] CODE_ENERGY    = 8'h22;
	localparam logic [7:0] CODE_AVG_PWR   = 8'h24;
	localparam logic [7:0] CODE_CP_RTE    = 8'h26;
	localparam logic [7:0] CODE_RESERVED  = 8'h28;
	localparam logic [7:0] CODE_CYCLES    = 8'h2a;
	localparam logic [7:0] CODE_CHARGE    = 8'h2c;
	localparam logic [7:0] CODE_LAST      = 8'h2d;
	localparam int         NUM_WORDS      = 23;

	// control subcommands
	localparam logic [15:0] SUB_STATUS      = 16'h0000;
	localparam logic [15:0] SUB_DEV_TYPE    = 16'h0001;
	localparam logic [15:0] SUB_FW_VER      = 16'h0002;
	localparam logic [15:0] SUB_HW_VER      = 16'h0003;
	localparam logic [15:0] SUB_PREV_WRITE  = 16'h0007;
	localparam logic [15:0] SUB_SET_DEEP    = 16'h0010;
	localparam logic [15:0] SUB_SET_HIB     = 16'h0011;
	localparam logic [15:0] SUB_CLR_HIB     = 16'h0012;
	localparam logic [15:0] SUB_SET_SHDN    = 16'h0013;
	localparam logic [15:0] SUB_CLR_SHDN    = 16'h0014;

	// status word bit positions
	localparam int ST_SE        = 15;
	localparam int ST_SHUTDOWN  = 7;
	localparam int ST_HIBERNATE = 6;
	localparam int ST_DEEP      = 5;
	localparam int ST_SLEEP     = 4;

	// user storage
	localparam int          FL_BLOCKS     = 3;
	localparam int          FL_BLOCK_SIZE = 32;
	localparam int          FL_BYTES      = FL_BLOCKS * FL_BLOCK_SIZE;
	localparam logic [1:0]  FL_LAST_BLOCK = 2'h2;

	localparam logic [2:0]  BYTE_BITS     = 3'h7;
	localparam logic [3:0]  BYTE_LEN      = 4'h8;

	typedef enum logic [6:0] {
		LK_IDLE  = 7'b0000001,
		LK_ADDR  = 7'b0000010,
		LK_AACK  = 7'b0000100,
		LK_RX    = 7'b0001000,
		LK_RXACK = 7'b0010000,
		LK_TX    = 7'b0100000,
		LK_TXACK = 7'b1000000
	} gsc_link_t;

	typedef enum logic [4:0] {
		PW_NORMAL    = 5'b00001,
		PW_SLEEP     = 5'b00010,
		PW_DEEP      = 5'b00100,
		PW_HIBERNATE = 5'b01000,
		PW_PREOFF    = 5'b10000
	} gsc_pwr_t;

endpackage : gsc_pkg

// ---- rtl/gsc_command_map.sv ----
`timescale 1ns/1ns
module gsc_command_map #(
	parameter logic [6:0]  DEV_ADDR    = 7'h3a,
	parameter logic [15:0] DEVICE_TYPE = 16'h1234, // arbitrary value
	parameter logic [15:0] FW_VERSION  = 16'h0100, // arbitrary value
	parameter logic [15:0] HW_VERSION  = 16'h0010  // arbitrary value
) (
	input  wire logic                              mclk,
	input  wire logic                              rst,
	input  wire logic                              ce,
	input  wire logic                              link_clk,
	input  wire logic                              scl_in,
	output logic                                   scl_out,
	output logic                                   scl_oe,
	input  wire logic                              sda_in,
	output logic                                   sda_out,
	output logic                                   sda_oe,
	input  wire logic [gsc_pkg::NUM_WORDS*16-1:0]  meas_words,
	input  wire logic                              sleep_cond,
	input  wire logic                              wake_cond,
	input  wire logic                              power_off_cond,
	output logic [4:0]                             power_state,
	output logic                                   se_active,
	input  wire logic                              fl_en,
	input  wire logic                              fl_wr,
	input  wire logic [1:0]                        fl_block,
	input  wire logic [4:0]                        fl_offset,
	input  wire logic [7:0]                        fl_wdata,
	output logic [7:0]                             fl_rdata,
	output logic                                   fl_err
);

	typedef struct packed {
		logic              scl_m;
		logic              scl_s;
		logic              scl_p;
		logic              sda_m;
		logic              sda_s;
		logic              sda_p;
		gsc_pkg::gsc_link_t ph;
		logic [3:0]        cnt;
		logic [7:0]        sh;
		logic              rw;
		logic              got_cmd;
		logic              nak;
		logic [7:0]        ptr;
		logic              req_t;
		logic              req_wr;
		logic [7:0]        req_addr;
		logic [7:0]        req_data;
		logic              ack_m;
		logic              ack_s;
		logic              ack_p;
		logic              have;
		logic [7:0]        rd;
		logic              sda_oe;
		logic              scl_oe;
		logic              sda_o;
		logic              scl_o;
	} gsc_link_state_t;

	typedef struct packed {
		logic                             rq_m;
		logic                             rq_s;
		logic                             rq_p;
		logic                             pend;
		logic                             ack_t;
		logic [7:0]                       rd_data;
		logic [7:0]                       ctrl_lo;
		logic [7:0]                       ar_lo;
		logic [15:0]                      ctrl_word;
		logic [15:0]                      at_rate;
		logic [15:0]                      last_sub;
		logic                             deep_req;
		logic                             hib_req;
		logic                             shdn_en;
		gsc_pkg::gsc_pwr_t                pwr;
		logic                             se;
		logic [gsc_pkg::FL_BYTES*8-1:0]   flash;
		logic [7:0]                       fl_rdata;
		logic                             fl_err;
	} gsc_core_state_t;

	gsc_link_state_t l;
	gsc_link_state_t next_l;
	gsc_core_state_t m;
	gsc_core_state_t next_m;

	// ---------------- link side: serial engine on its own clock ----------------
	logic link_start;
	logic link_stop;
	logic link_rise;
	logic link_fall;

	always_comb begin
		next_l = l;
		next_l.scl_m = scl_in;
		next_l.scl_s = l.scl_m;
		next_l.scl_p = l.scl_s;
		next_l.sda_m = sda_in;
		next_l.sda_s = l.sda_m;
		next_l.sda_p = l.sda_s;
		next_l.ack_m = m.ack_t;
		next_l.ack_s = l.ack_m;
		next_l.ack_p = l.ack_s;
		link_start = l.scl_s && l.scl_p && l.sda_p && !l.sda_s;
		link_stop  = l.scl_s && l.scl_p && !l.sda_p && l.sda_s;
		link_rise  = l.scl_s && !l.scl_p;
		link_fall  = !l.scl_s && l.scl_p;
		// the answer byte was frozen by the core on the same edge as it toggled back
		if (l.ack_s ^ l.ack_p) begin
			next_l.have = 1'b1;
			next_l.rd   = m.rd_data;
		end
		if (link_start) begin
			next_l.ph      = gsc_pkg::LK_ADDR;
			next_l.cnt     = '0;
			next_l.got_cmd = 1'b0;
			next_l.sda_oe  = 1'b0;
			next_l.scl_oe  = 1'b0;
		end else if (link_stop) begin
			next_l.ph     = gsc_pkg::LK_IDLE;
			next_l.sda_oe = 1'b0;
			next_l.scl_oe = 1'b0;
		end else begin
			unique case (l.ph)
				gsc_pkg::LK_IDLE: begin
					next_l.sda_oe = 1'b0;
				end
				gsc_pkg::LK_ADDR, gsc_pkg::LK_RX: begin
					if (link_rise) begin
						next_l.sh  = {l.sh[6:0], l.sda_s};
						next_l.cnt = l.cnt + 4'h1;
					end else if (link_fall && l.cnt == gsc_pkg::BYTE_LEN) begin
						next_l.cnt = '0;
						if (l.ph == gsc_pkg::LK_ADDR) begin
							if (l.sh[7:1] == DEV_ADDR) begin
								next_l.rw     = l.sh[0];
								next_l.sda_oe = 1'b1;
								next_l.ph     = gsc_pkg::LK_AACK;
								if (l.sh[0]) begin
									// fetch early so the stretch is usually short
									next_l.req_t    = ~l.req_t;
									next_l.req_wr   = 1'b0;
									next_l.req_addr = l.ptr;
									next_l.ptr      = l.ptr + 8'h01;
									next_l.have     = 1'b0;
								end
							end else begin
								next_l.ph = gsc_pkg::LK_IDLE;
							end
						end else begin
							next_l.sda_oe = 1'b1;
							next_l.ph     = gsc_pkg::LK_RXACK;
							if (!l.got_cmd) begin
								next_l.ptr     = l.sh;
								next_l.got_cmd = 1'b1;
							end else begin
								next_l.req_t    = ~l.req_t;
								next_l.req_wr   = 1'b1;
								next_l.req_addr = l.ptr;
								next_l.req_data = l.sh;
								next_l.ptr      = l.ptr + 8'h01;
							end
						end
					end
				end
				gsc_pkg::LK_AACK: begin
					if (link_fall) begin
						next_l.sda_oe = 1'b0;
						next_l.ph     = l.rw ? gsc_pkg::LK_TX : gsc_pkg::LK_RX;
					end
				end
				gsc_pkg::LK_RXACK: begin
					if (link_fall) begin
						next_l.sda_oe = 1'b0;
						next_l.ph     = gsc_pkg::LK_RX;
					end
				end
				gsc_pkg::LK_TX: begin
					// a stretch ends one cycle after the data bit, never with it
					next_l.scl_oe = 1'b0;
					if (l.cnt == '0) begin
						// hold the clock low until the core has answered
						if (next_l.have) begin
							next_l.sh     = next_l.rd;
							next_l.sda_oe = ~next_l.rd[7];
							next_l.scl_oe = l.scl_oe;
							next_l.cnt    = 4'h1;
							next_l.have   = 1'b0;
						end else begin
							next_l.scl_oe = 1'b1;
						end
					end else if (link_fall) begin
						if (l.cnt == gsc_pkg::BYTE_LEN) begin
							next_l.sda_oe = 1'b0;
							next_l.cnt    = '0;
							next_l.ph     = gsc_pkg::LK_TXACK;
						end else begin
							next_l.sh     = {l.sh[6:0], 1'b0};
							next_l.sda_oe = ~l.sh[6];
							next_l.cnt    = l.cnt + 4'h1;
						end
					end
				end
				gsc_pkg::LK_TXACK: begin
					if (link_rise) begin
						next_l.nak = l.sda_s;
						if (!l.sda_s) begin
							next_l.req_t    = ~l.req_t;
							next_l.req_wr   = 1'b0;
							next_l.req_addr = l.ptr;
							next_l.ptr      = l.ptr + 8'h01;
							next_l.have     = 1'b0;
						end
					end else if (link_fall) begin
						next_l.ph = l.nak ? gsc_pkg::LK_IDLE : gsc_pkg::LK_TX;
					end
				end
			endcase
		end
	end

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			l       <= '0;
			l.scl_m <= 1'b1;
			l.scl_s <= 1'b1;
			l.scl_p <= 1'b1;
			l.sda_m <= 1'b1;
			l.sda_s <= 1'b1;
			l.sda_p <= 1'b1;
			l.ph    <= gsc_pkg::LK_IDLE;
		end else begin
			l <= next_l;
		end
	end

	// ---------------- core side: map, power states, storage ----------------
	logic [6:0]  word_idx;
	logic [15:0] rword;
	logic [15:0] sub;
	logic [6:0]  fl_idx;
	logic        serve;

	always_comb begin
		next_m = m;
		next_m.rq_m = l.req_t;
		next_m.rq_s = m.rq_m;
		next_m.rq_p = m.rq_s;
		if (m.rq_s ^ m.rq_p)
			next_m.pend = 1'b1;
		word_idx = l.req_addr[7:1];
		sub      = {l.req_data, m.ctrl_lo};
		fl_idx   = {fl_block, fl_offset};

		// a host access pulls the gauge up toward the normal state from sleep, deep or hibernate, but not out of pre-off
		unique case (m.pwr)
			gsc_pkg::PW_NORMAL: begin
				if (power_off_cond && m.shdn_en)
					next_m.pwr = gsc_pkg::PW_PREOFF;
				else if (sleep_cond && !next_m.pend)
					next_m.pwr = gsc_pkg::PW_SLEEP;
			end
			gsc_pkg::PW_SLEEP: begin
				if (next_m.pend || wake_cond)
					next_m.pwr = gsc_pkg::PW_NORMAL;
				else if (m.hib_req)
					next_m.pwr = gsc_pkg::PW_HIBERNATE;
				else if (m.deep_req)
					next_m.pwr = gsc_pkg::PW_DEEP;
			end
			gsc_pkg::PW_DEEP: begin
				if (next_m.pend || wake_cond) begin
					next_m.pwr      = gsc_pkg::PW_SLEEP;
					next_m.deep_req = 1'b0;
				end
			end
			gsc_pkg::PW_HIBERNATE: begin
				if (next_m.pend || wake_cond || !m.hib_req) begin
					next_m.pwr     = gsc_pkg::PW_NORMAL;
					next_m.hib_req = 1'b0;
				end
			end
			gsc_pkg::PW_PREOFF: begin
				if (!power_off_cond || !m.shdn_en)
					next_m.pwr = gsc_pkg::PW_NORMAL;
			end
		endcase
		next_m.se = m.shdn_en && (m.pwr == gsc_pkg::PW_PREOFF);

		// a request waits until the gauge is in the normal state; only a read keeps the link stretched meanwhile
		serve = next_m.pend && m.pwr == gsc_pkg::PW_NORMAL;
		if (word_idx == gsc_pkg::CODE_CONTROL[7:1])
			rword = m.ctrl_word;
		else if (word_idx == gsc_pkg::CODE_AT_RATE[7:1])
			rword = m.at_rate;
		else if (l.req_addr > gsc_pkg::CODE_LAST || word_idx == gsc_pkg::CODE_RESERVED[7:1])
			rword = '0;
		else
			rword = meas_words[{word_idx[4:0], 4'h0} +: 16];
		if (serve) begin
			next_m.pend  = 1'b0;
			next_m.ack_t = ~m.ack_t;
			if (!l.req_wr) begin
				next_m.rd_data = l.req_addr[0] ? rword[15:8] : rword[7:0];
			end else if (l.req_addr == gsc_pkg::CODE_CONTROL) begin
				next_m.ctrl_lo = l.req_data;
			end else if (l.req_addr == gsc_pkg::CODE_AT_RATE) begin
				next_m.ar_lo = l.req_data;
			end else if (l.req_addr == (gsc_pkg::CODE_AT_RATE | 8'h01)) begin
				next_m.at_rate = {l.req_data, m.ar_lo};
			end else if (l.req_addr == (gsc_pkg::CODE_CONTROL | 8'h01)) begin
				// the word takes effect only once its high byte lands
				next_m.last_sub = sub;
				unique case (sub)
					gsc_pkg::SUB_STATUS: begin
						next_m.ctrl_word = '0;
						next_m.ctrl_word[gsc_pkg::ST_SE]        = m.se;
						next_m.ctrl_word[gsc_pkg::ST_SHUTDOWN]  = m.shdn_en;
						next_m.ctrl_word[gsc_pkg::ST_HIBERNATE] = m.hib_req;
						next_m.ctrl_word[gsc_pkg::ST_DEEP]      = m.deep_req;
						next_m.ctrl_word[gsc_pkg::ST_SLEEP]     = m.pwr == gsc_pkg::PW_SLEEP;
					end
					gsc_pkg::SUB_DEV_TYPE:   next_m.ctrl_word = DEVICE_TYPE;
					gsc_pkg::SUB_FW_VER:     next_m.ctrl_word = FW_VERSION;
					gsc_pkg::SUB_HW_VER:     next_m.ctrl_word = HW_VERSION;
					gsc_pkg::SUB_PREV_WRITE: next_m.ctrl_word = m.last_sub;
					gsc_pkg::SUB_SET_DEEP:   next_m.deep_req  = 1'b1;
					gsc_pkg::SUB_SET_HIB:    next_m.hib_req   = 1'b1;
					gsc_pkg::SUB_CLR_HIB:    next_m.hib_req   = 1'b0;
					gsc_pkg::SUB_SET_SHDN:   next_m.shdn_en   = 1'b1;
					gsc_pkg::SUB_CLR_SHDN:   next_m.shdn_en   = 1'b0;
					default: begin
					end
				endcase
			end
		end

		// storage is only on its own port, never on the command codes
		next_m.fl_err = 1'b0;
		if (fl_en) begin
			if (fl_block > gsc_pkg::FL_LAST_BLOCK) begin
				next_m.fl_err = 1'b1;
			end else if (fl_wr) begin
				next_m.flash[{fl_idx, gsc_pkg::BYTE_BITS} -: 8] = fl_wdata;
			end else begin
				next_m.fl_rdata = m.flash[{fl_idx, gsc_pkg::BYTE_BITS} -: 8];
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			m     <= '0;
			m.pwr <= gsc_pkg::PW_NORMAL;
		end else if (ce) begin
			m <= next_m;
		end
	end

	assign scl_out     = l.scl_o;
	assign scl_oe      = l.scl_oe;
	assign sda_out     = l.sda_o;
	assign sda_oe      = l.sda_oe;
	assign power_state = m.pwr;
	assign se_active   = m.se;
	assign fl_rdata    = m.fl_rdata;
	assign fl_err      = m.fl_err;

endmodule : gsc_command_map

// ---- sim/gsc_command_map_properties.sv ----
`timescale 1ns/1ns
module gsc_props (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       ce,
	input wire logic       link_clk,
	input wire logic       scl_in,
	input wire logic       scl_out,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic [4:0] power_state,
	input wire logic       se_active,
	input wire logic       fl_en,
	input wire logic       fl_wr,
	input wire logic [1:0] fl_block,
	input wire logic [7:0] fl_rdata,
	input wire logic       fl_err
);
	a_state_onehot: assert property (@(posedge mclk) disable iff (rst)
		$onehot(power_state)) else $error("power state not one-hot");
	a_pins_open_drain: assert property (@(posedge mclk) disable iff (rst)
		scl_out == 1'b0 && sda_out == 1'b0) else $error("bus pin driven high");
	a_fl_err_cause: assert property (@(posedge mclk) disable iff (rst)
		ce && fl_en && fl_block == 2'h3 |=> fl_err) else $error("bad block not flagged");
	a_fl_err_only: assert property (@(posedge mclk) disable iff (rst)
		fl_err |-> $past(ce && fl_en && fl_block == 2'h3)) else $error("spurious storage error");
	a_rdata_cause: assert property (@(posedge mclk) disable iff (rst)
		!$stable(fl_rdata) |-> $past(ce && fl_en && !fl_wr)) else $error("read data moved alone");
	a_se_in_preoff: assert property (@(posedge mclk) disable iff (rst)
		se_active |-> $past(power_state) == gsc_pkg::PW_PREOFF) else $error("se outside pre-off");
	a_normal_exit: assert property (@(posedge mclk) disable iff (rst)
		$past(power_state) == gsc_pkg::PW_NORMAL && power_state != gsc_pkg::PW_NORMAL
		|-> power_state inside {gsc_pkg::PW_SLEEP, gsc_pkg::PW_PREOFF})
		else $error("illegal exit from normal");
	a_hib_from_sleep: assert property (@(posedge mclk) disable iff (rst)
		$rose(power_state[3]) |-> $past(power_state) == gsc_pkg::PW_SLEEP)
		else $error("hibernate not entered from sleep");
	// data may only move while the clock line is low, else it reads as start or stop
	a_sda_moves_low: assert property (@(posedge link_clk) disable iff (rst)
		!$stable(sda_oe) |-> !scl_in) else $error("data changed with clock high");
endmodule : gsc_props

bind gsc_command_map gsc_props u_props (.mclk(mclk), .rst(rst), .ce(ce), .link_clk(link_clk),
	.scl_in(scl_in), .scl_out(scl_out), .sda_out(sda_out), .sda_oe(sda_oe),
	.power_state(power_state), .se_active(se_active), .fl_en(fl_en), .fl_wr(fl_wr),
	.fl_block(fl_block), .fl_rdata(fl_rdata), .fl_err(fl_err));

// ---- sim/gsc_host.sv ----
`timescale 1ns/1ns
module gsc_host #(
	parameter logic [6:0] ADDR = 7'h3a,
	parameter int         Q    = 1000
) (
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_low,
	output logic      sda_low,
	output logic      hung
);
	logic [7:0] rx;
	event       got;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		hung = 1'b0;
	end
	// the gauge may stretch the clock while asleep; give up after a bound
	task rise;
		int n;
		scl_low = 1'b0;
		for (n = 0; n < 8000 && scl !== 1'b1; n++)
			#50;
		if (scl !== 1'b1)
			hung = 1'b1;
		#Q;
	endtask : rise
	task bit_io(input logic b, output logic s);
		sda_low = !b;
		#Q;
		rise;
		s = sda;
		scl_low = 1'b1;
		#Q;
	endtask : bit_io
	task start_c;
		sda_low = 1'b0;
		#Q;
		rise;
		sda_low = 1'b1;
		#Q;
		scl_low = 1'b1;
		#Q;
	endtask : start_c
	task stop_c;
		sda_low = 1'b1;
		#Q;
		rise;
		sda_low = 1'b0;
		#(2*Q);
	endtask : stop_c
	task send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask : send_byte
	task recv_byte(input logic last);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			rx[i] = s;
		end
		bit_io(last, s);
		-> got;
	endtask : recv_byte
	// code byte then both data bytes, so a subcommand always arrives whole
	task write_word(input logic [6:0] a, input logic [7:0] code, input logic [15:0] w,
			output logic ok);
		logic k0, k1, k2, k3;
		start_c;
		send_byte({a, 1'b0}, k0);
		send_byte(code, k1);
		send_byte(w[7:0], k2);
		send_byte(w[15:8], k3);
		stop_c;
		ok = k0 & k1 & k2 & k3;
	endtask : write_word
	task read_seq(input logic [7:0] code, input int n);
		logic k;
		start_c;
		send_byte({ADDR, 1'b0}, k);
		send_byte(code, k);
		start_c;
		send_byte({ADDR, 1'b1}, k);
		for (int i = 0; i < n; i++)
			recv_byte(i == n - 1);
		stop_c;
	endtask : read_seq
endmodule : gsc_host

// ---- sim/test_gauge_standard_command_map.sv ----
`timescale 1ns/1ns
module test_gauge_standard_command_map;
	localparam logic [15:0] DEV_TYPE = 16'h2b7c; // arbitrary value
	localparam logic [15:0] FW_VER   = 16'h5e21; // arbitrary value
	localparam logic [15:0] HW_VER   = 16'h0c3d; // arbitrary value
	logic                             mclk, rst, ce, link_clk, ok, hung, pend = 1'b0;
	logic                             scl_out, scl_oe, sda_out, sda_oe, h_scl, h_sda;
	logic                             sleep_cond, wake_cond, power_off_cond, se_active;
	logic                             fl_en, fl_wr, fl_err;
	logic [1:0]                       fl_block;
	logic [4:0]                       fl_offset, power_state;
	logic [7:0]                       fl_wdata, fl_rdata, mem [96], q_bus [$], q_fl [$];
	logic [15:0]                      w, sub [4], expw [4];
	logic [gsc_pkg::NUM_WORDS*16-1:0] meas_words;
	int                               miscompares, n_tests, seed, n;
	wire                              scl_w = !h_scl & (scl_oe ? scl_out : 1'b1);
	wire                              sda_w = !h_sda & (sda_oe ? sda_out : 1'b1);

	gsc_command_map #(.DEVICE_TYPE(DEV_TYPE), .FW_VERSION(FW_VER), .HW_VERSION(HW_VER)) DUT (
		.mclk(mclk), .rst(rst), .ce(ce),
		.link_clk(link_clk), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .meas_words(meas_words),
		.sleep_cond(sleep_cond), .wake_cond(wake_cond), .power_off_cond(power_off_cond),
		.power_state(power_state), .se_active(se_active), .fl_en(fl_en), .fl_wr(fl_wr),
		.fl_block(fl_block), .fl_offset(fl_offset), .fl_wdata(fl_wdata),
		.fl_rdata(fl_rdata), .fl_err(fl_err));
	gsc_host host (.scl(scl_w), .sda(sda_w), .scl_low(h_scl), .sda_low(h_sda), .hung(hung));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		link_clk = 1'b0;
		#37;
		forever #80 link_clk = ~link_clk;
	end

	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check
	task end_sim;
		$display("miscompares %0d, n_tests %0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim
	task tick;
		@(posedge mclk);
		#2;
	endtask : tick
	task wait_ps(input logic [4:0] s);
		for (int k = 0; k < 4000 && power_state !== s; k++)
			tick;
		check(power_state, s);
	endtask : wait_ps
	task rd_word(input logic [7:0] code, input logic [15:0] v);
		q_bus.push_back(v[7:0]);
		q_bus.push_back(v[15:8]);
		host.read_seq(code, 2);
	endtask : rd_word

	initial forever begin
		@(host.got);
		check(host.rx, q_bus.pop_front());
	end
	always @(posedge mclk) begin
		if (pend)
			check(fl_rdata, q_fl.pop_front());
		pend <= fl_en & ce & !fl_wr;
	end
	always @(posedge hung) begin
		miscompares++;
		end_sim;
	end

	initial begin
		seed = 32'h8c56;
		{rst, ce, sleep_cond, wake_cond, power_off_cond} = 5'h18;
		{fl_en, fl_wr, fl_block, fl_offset, fl_wdata} = 17'h00000;
		for (n = 0; n < gsc_pkg::NUM_WORDS; n++)
			meas_words[16*n +: 16] = 16'($random(seed));
		repeat (5) @(posedge mclk);
		#2;
		rst = 1'b0;
		check({fl_err, power_state, se_active, sda_oe, scl_oe}, 16'h0008);
		check(fl_rdata, 16'h0000);
		repeat (12) tick;
		for (n = 0; n < 97; n++) begin
			tick;
			{fl_en, fl_wr} = 2'h3;
			{fl_block, fl_offset} = 7'(n);
			fl_wdata = 8'($random(seed));
			mem[n % 96] = (n < 96) ? fl_wdata : mem[0];
		end
		for (n = 0; n < 96; n++) begin
			tick;
			if (n < 2)
				check(fl_err, n == 0);
			fl_wr = 1'b0;
			{fl_block, fl_offset} = 7'(n);
			q_fl.push_back(mem[n]);
		end
		tick;
		// with the core frozen a read must leave the last data in place
		ce = 1'b0;
		fl_offset = 5'h00;
		repeat (2) tick;
		check(fl_rdata, mem[95]);
		{ce, fl_en} = 2'h2;
		w = 16'($random(seed));
		host.write_word(7'h3a, gsc_pkg::CODE_AT_RATE, w, ok);
		check(ok, 1'b1);
		host.write_word(7'h3b, gsc_pkg::CODE_AT_RATE, ~w, ok);
		check(ok, 1'b0);
		host.write_word(7'h3a, gsc_pkg::CODE_POTENTIAL, ~w, ok);
		rd_word(gsc_pkg::CODE_AT_RATE, w);
		// one spooled read walks every read-only word, the reserved pair and one code past the end
		for (n = 4; n < 8'h2f; n++)
			q_bus.push_back((n < 8'h2e && n / 2 != 20) ? meas_words[8*n +: 8] : 8'h00);
		host.read_seq(gsc_pkg::CODE_AR_TTE, 43);
		sub = '{gsc_pkg::SUB_DEV_TYPE, gsc_pkg::SUB_FW_VER, gsc_pkg::SUB_HW_VER,
			gsc_pkg::SUB_PREV_WRITE};
		// the last one reports the subcommand written just before it
		expw = '{DEV_TYPE, FW_VER, HW_VER, gsc_pkg::SUB_HW_VER};
		for (n = 0; n < 4; n++) begin
			host.write_word(7'h3a, gsc_pkg::CODE_CONTROL, sub[n], ok);
			rd_word(gsc_pkg::CODE_CONTROL, expw[n]);
		end
		host.write_word(7'h3a, gsc_pkg::CODE_CONTROL, gsc_pkg::SUB_SET_SHDN, ok);
		host.write_word(7'h3a, gsc_pkg::CODE_CONTROL, gsc_pkg::SUB_SET_HIB, ok);
		tick;
		sleep_cond = 1'b1;
		wait_ps(gsc_pkg::PW_HIBERNATE);
		sleep_cond = 1'b0;
		// this access has to wake the gauge before it is served
		host.write_word(7'h3a, gsc_pkg::CODE_CONTROL, gsc_pkg::SUB_STATUS, ok);
		check(power_state, gsc_pkg::PW_NORMAL);
		rd_word(gsc_pkg::CODE_CONTROL, 16'h0080);
		host.write_word(7'h3a, gsc_pkg::CODE_CONTROL, gsc_pkg::SUB_SET_DEEP, ok);
		tick;
		sleep_cond = 1'b1;
		wait_ps(gsc_pkg::PW_DEEP);
		sleep_cond = 1'b0;
		// the read request itself wakes the gauge through sleep back to normal
		rd_word(gsc_pkg::CODE_CONTROL, 16'h0080);
		check(power_state, gsc_pkg::PW_NORMAL);
		tick;
		power_off_cond = 1'b1;
		wait_ps(gsc_pkg::PW_PREOFF);
		tick;
		check(se_active, 1'b1);
		end_sim;
	end
endmodule : test_gauge_standard_command_map
